// File: scp_regs.vh
// How it works
// RULE_01: chip select low, first eight bits command
// RULE_02: write command stores following bytes in storage
// RULE_03: read returns identification byte, then data bytes
// RULE_04: data input sampled on serial clock rise
// RULE_05: data output changes on serial clock fall
// RULE_06: ignore data input while read data returns
// RULE_07: host raises chip select; command ends there
// RULE_08: host releases shared line during read data
// RULE_09: long clock-high pauses between bytes keep state
// RULE_10: host needs only a half-duplex port
// RULE_11: interrupt output high on signaling input change
// RULE_12: system keeps line master clock running always
// RULE_13: data output floats unless returning read data
// RULE_14: command bits 3 and 4 pick class
// RULE_15: at most eight data bytes each way
// RULE_16: every byte travels most significant bit first
// RULE_17: early chip select rise drops partial byte
`ifndef SCP_REGS_VH
`define SCP_REGS_VH

// command byte fields
`define SCP_CMD_CLS_LO    3
`define SCP_CMD_CLS_HI    4
`define SCP_CMD_RD_BIT    5
`define SCP_CMD_CNT_HI    2
`define SCP_CMD_CH_LO     6
`define SCP_CMD_CH_HI     7

// storage class codes after decode
`define SCP_CLS_COEF      2'h0
`define SCP_CLS_STAT      2'h2
`define SCP_CLS_EXT       2'h3

// identification byte, value arbitrary
`define SCP_ID_BYTE       8'h5a

// reset value of storage bytes
`define SCP_MEM_RST       8'h00

// signal input debounce, in ref_clk cycles
`define SCP_DEB_CYCLES    16'h0040

// serial state codes
`define SCP_ST_IDLE       3'h0
`define SCP_ST_CMD        3'h1
`define SCP_ST_WDATA      3'h2
`define SCP_ST_RDATA      3'h3
`define SCP_ST_DONE       3'h4

`endif

// File: scp_sig_irq.v
`timescale 1ns/1ps
`default_nettype none
`include "scp_regs.vh"

// debounces synchronised signaling inputs and raises a sticky interrupt
module scp_sig_irq #(
    parameter             SIG_W = 8,
    parameter [15:0]      DEB   = `SCP_DEB_CYCLES
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [SIG_W-1:0] sig_s,
    input  wire             clr,
    output reg  [SIG_W-1:0] stable_q,
    output reg              irq_q
);

    reg [SIG_W-1:0] cand_q;   // last value seen on the inputs
    reg [15:0]      cnt_q;    // cycles the candidate has held
    wire            evt;      // stable value changes this cycle

    // a change counts only once it has held for the debounce time
    assign evt = (cnt_q == DEB) && (cand_q != stable_q);

    // debounce counter; restarts on any wiggle so glitches never fire
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cand_q   <= {SIG_W{1'b0}};
            cnt_q    <= 16'h0000;
            stable_q <= {SIG_W{1'b0}};
        end else begin
            cand_q <= sig_s;
            if (sig_s != cand_q) begin
                cnt_q <= 16'h0000;
            end else if (cnt_q != DEB) begin
                cnt_q <= cnt_q + 16'h0001;
            end
            if (evt) begin
                stable_q <= cand_q;
            end
        end
    end

    // sticky flag; a change in the clearing cycle still sets it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else if (evt) begin
            irq_q <= 1'b1; // RULE_11
        end else if (clr) begin
            irq_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// File: scp_top.v
`timescale 1ns/1ps
`default_nettype none
`include "scp_regs.vh"

// serial control port: command decode, byte storage, read-back, interrupt
module scp_top #(
    parameter             SIG_W = 8,
    parameter [15:0]      DEB   = `SCP_DEB_CYCLES
) (
    input  wire             ref_clk,
    input  wire             rstn,
    input  wire             cs_n,
    input  wire             serial_clock,
    input  wire             din,
    output reg              dout_q,
    output reg              dout_oe_q,
    input  wire [SIG_W-1:0] sig_in,
    output reg              irq_q
);

    // reset release chain; assertion stays asynchronous
    reg  [1:0]       rst_q;
    wire             rst_n;

    // two-flop synchronisers plus one history stage for edge finding
    reg  [1:0]       cs_s_q;
    reg  [1:0]       sck_s_q;
    reg  [1:0]       din_s_q;
    reg  [SIG_W-1:0] sig_m_q;
    reg  [SIG_W-1:0] sig_s_q;
    reg              sck_h_q;
    reg              cs_h_q;

    // serial engine state
    reg  [2:0]       st_q;
    reg  [2:0]       bit_q;      // bits received in current byte
    reg  [7:0]       rx_q;       // receive shift register
    reg  [7:0]       cmd_q;      // latched command byte
    reg  [2:0]       idx_q;      // byte index into storage
    reg  [7:0]       tx_q;       // transmit shift register
    reg  [2:0]       txb_q;      // bits sent of current byte
    reg              tx_id_q;    // identification byte not yet loaded
    reg              tx_last_q;  // the byte now shifting is the last
    reg              clr_q;      // one-cycle interrupt clear

    // byte storage: coefficient, status and extended classes per channel
    reg  [7:0]       mem_q [0:127];
    wire [SIG_W-1:0] sig_stable;
    wire             irq_w;
    wire             sck_rise;
    wire             sck_fall;
    wire             cs_act;
    wire [7:0]       rx_byte;
    wire [7:0]       rd_byte;
    wire [7:0]       id_byte;    // identification value, arbitrary
    integer          i;

    // command class from bits 3 and 4: 0x coefficient, 10 status, 11 extended
    function [1:0] scp_cls;
        input [7:0] c;
        begin
            scp_cls = {c[`SCP_CMD_CLS_HI],
                       c[`SCP_CMD_CLS_HI] & c[`SCP_CMD_CLS_LO]}; // RULE_14
        end
    endfunction

    // storage index from class, channel and byte position
    function [6:0] scp_addr;
        input [7:0] c;
        input [2:0] n;
        begin
            scp_addr = {scp_cls(c), c[`SCP_CMD_CH_HI:`SCP_CMD_CH_LO], n};
        end
    endfunction

    assign rst_n    = rst_q[1];
    assign sck_rise = sck_s_q[1] & ~sck_h_q;
    assign sck_fall = ~sck_s_q[1] & sck_h_q;
    assign cs_act   = ~cs_s_q[1];
    assign rx_byte  = {rx_q[6:0], din_s_q[1]}; // RULE_16
    assign id_byte  = `SCP_ID_BYTE;
    // extended byte 0 reflects the debounced signal inputs
    assign rd_byte  = (scp_cls(cmd_q) == `SCP_CLS_EXT && idx_q == 3'h0)
                      ? sig_stable[7:0] : mem_q[scp_addr(cmd_q, idx_q)];

    // reset synchroniser
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end

    // pin synchronisers; only the second stage feeds any logic
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s_q  <= 2'b11;
            sck_s_q <= 2'b11;
            din_s_q <= 2'b00;
            sig_m_q <= {SIG_W{1'b0}};
            sig_s_q <= {SIG_W{1'b0}};
            sck_h_q <= 1'b1;
            cs_h_q  <= 1'b1;
        end else begin
            cs_s_q  <= {cs_s_q[0], cs_n};
            sck_s_q <= {sck_s_q[0], serial_clock};
            din_s_q <= {din_s_q[0], din};
            sig_m_q <= sig_in;
            sig_s_q <= sig_m_q;
            sck_h_q <= sck_s_q[1];
            cs_h_q  <= cs_s_q[1];
        end
    end

    // receive side and command sequencing on serial clock rise; read index step and read end on serial clock fall
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= `SCP_ST_IDLE;
            bit_q <= 3'h0;
            rx_q  <= 8'h00;
            cmd_q <= 8'h00;
            idx_q <= 3'h0;
            clr_q <= 1'b0;
            for (i = 0; i < 128; i = i + 1) begin
                mem_q[i] <= `SCP_MEM_RST;
            end
        end else begin
            clr_q <= 1'b0;
            if (!cs_act) begin
                // chip select high ends any command and drops partial bytes
                st_q  <= `SCP_ST_IDLE; // RULE_07 RULE_17
                bit_q <= 3'h0;
            end else if (cs_h_q) begin
                // falling chip select: next eight bits form the command
                st_q  <= `SCP_ST_CMD; // RULE_01
                bit_q <= 3'h0;
            end else if (sck_rise) begin
                // state is held between edges, so pauses cost nothing
                case (st_q) // RULE_09
                    `SCP_ST_CMD: begin
                        rx_q  <= rx_byte; // RULE_04
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            cmd_q <= rx_byte;
                            // count field is bytes minus one, eight at most
                            idx_q <= rx_byte[`SCP_CMD_CNT_HI:0]; // RULE_15
                            if (rx_byte[`SCP_CMD_RD_BIT]) begin
                                st_q <= `SCP_ST_RDATA; // RULE_03
                                // reading the extended class acknowledges
                                clr_q <= (scp_cls(rx_byte) == `SCP_CLS_EXT);
                            end else begin
                                st_q <= `SCP_ST_WDATA;
                            end
                        end
                    end
                    `SCP_ST_WDATA: begin
                        rx_q  <= rx_byte;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            // first byte lands in the highest index
                            mem_q[scp_addr(cmd_q, idx_q)] <= rx_byte; // RULE_02
                            idx_q <= idx_q - 3'h1;
                            if (idx_q == 3'h0) begin
                                st_q <= `SCP_ST_DONE;
                            end
                        end
                    end
                    `SCP_ST_RDATA: begin
                        // data input is not looked at while returning data
                        bit_q <= 3'h0; // RULE_06
                    end
                    `SCP_ST_DONE: begin
                        bit_q <= 3'h0;
                    end
                    default: begin
                        bit_q <= 3'h0;
                    end
                endcase
            end else if (st_q == `SCP_ST_RDATA && sck_fall && txb_q == 3'h0
                         && tx_last_q) begin
                // last bit has had its rise; the fall after it ends the read
                st_q <= `SCP_ST_DONE;
            end else if (st_q == `SCP_ST_RDATA && sck_fall && txb_q == 3'h0
                         && !tx_id_q) begin
                // a data byte was just loaded; step to the next one down
                idx_q <= idx_q - 3'h1;
            end
        end
    end

    // transmit side: new bit on each serial clock fall during read data
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b0;
            tx_q      <= 8'h00;
            txb_q     <= 3'h0;
            tx_id_q   <= 1'b1;
            tx_last_q <= 1'b0;
        end else if (st_q != `SCP_ST_RDATA) begin
            // output floats whenever no read data is due
            dout_oe_q <= 1'b0; // RULE_13
            txb_q     <= 3'h0;
            tx_id_q   <= 1'b1;
            tx_last_q <= 1'b0;
        end else if (sck_fall && txb_q == 3'h0 && tx_last_q) begin
            // dropping earlier would lose the last bit before the host samples it
            dout_oe_q <= 1'b0; // RULE_13
        end else if (sck_fall) begin
            dout_oe_q <= 1'b1; // RULE_08
            txb_q     <= txb_q + 3'h1;
            if (txb_q == 3'h0) begin
                if (tx_id_q) begin
                    // identification goes out ahead of the data
                    dout_q    <= id_byte[7]; // RULE_03
                    tx_q      <= {id_byte[6:0], 1'b0};
                    tx_id_q   <= 1'b0;
                end else begin
                    dout_q    <= rd_byte[7]; // RULE_05 RULE_16
                    tx_q      <= {rd_byte[6:0], 1'b0};
                    tx_last_q <= (idx_q == 3'h0);
                end
            end else begin
                dout_q <= tx_q[7]; // RULE_05
                tx_q   <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // signaling input change detector and sticky interrupt
    scp_sig_irq #(
        .SIG_W (SIG_W),
        .DEB   (DEB)
    ) u_sig (
        .clk      (ref_clk),
        .rst_n    (rst_n),
        .sig_s    (sig_s_q),
        .clr      (clr_q),
        .stable_q (sig_stable),
        .irq_q    (irq_w)
    );

    // output copy keeps the pin straight from a flop
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_w; // RULE_11
        end
    end

endmodule
`default_nettype wire

// File: scp_checker.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level watcher for the serial port and the interrupt output
module scp_checker #(
    parameter        SIG_W = 8,
    parameter [15:0] DEB   = 16'h0040
) (
    input wire logic             ref_clk,
    input wire logic             rstn,
    input wire logic             cs_n,
    input wire logic             serial_clock,
    input wire logic             din,
    input wire logic             dout_q,
    input wire logic             dout_oe_q,
    input wire logic [SIG_W-1:0] sig_in,
    input wire logic             irq_q
);
    logic             sclk_q;   // serial clock seen last cycle
    logic [7:0]       fall_age; // cycles since the last clock fall
    logic [SIG_W-1:0] sig_q;    // signaling inputs seen last cycle
    logic [15:0]      sig_age;  // cycles since inputs last moved
    // both ages saturate, so long host pauses never wrap around
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q   <= 1'b1;
            fall_age <= 8'hff;
            sig_q    <= '0;
            sig_age  <= 16'hffff;
        end else begin
            sclk_q   <= serial_clock;
            sig_q    <= sig_in;
            fall_age <= (sclk_q && !serial_clock) ? 8'h00 :
                        (fall_age == 8'hff) ? fall_age : fall_age + 8'h01;
            sig_age  <= (sig_in != sig_q) ? 16'h0000 :
                        (sig_age == 16'hffff) ? sig_age : sig_age + 16'h0001;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    reset_quiet_a: assert property ($rose(rstn) |-> !dout_oe_q && !irq_q)
        else $error("outputs active right after reset");
    oe_idle_a: assert property (cs_n [*6] |-> !dout_oe_q)
        else $error("data output driven while deselected");
    oe_start_a: assert property ($rose(dout_oe_q) |-> fall_age <= 8'd8)
        else $error("output enable rose without a clock fall");
    dout_edge_a: assert property (dout_oe_q && $past(dout_oe_q) && $changed(dout_q)
        |-> fall_age <= 8'd8) else $error("data output moved away from a clock fall");
    oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !dout_oe_q)
        else $error("output still driven after deselect");
    pause_hold_a: assert property ($fell(dout_oe_q) |-> fall_age <= 8'd8 || cs_n)
        else $error("output dropped during a clock pause");
    irq_cause_a: assert property ($rose(irq_q)
        |-> sig_age >= DEB && sig_age <= DEB + 16'h000c) else $error("interrupt timing wrong");
    irq_clear_a: assert property ($fell(irq_q) |-> !$past(cs_n, 3))
        else $error("interrupt cleared outside an access");
    cover property ($rose(dout_oe_q));
    cover property ($rose(irq_q));
    cover property ($fell(irq_q));
endmodule
bind scp_top scp_checker #(.SIG_W(SIG_W), .DEB(DEB)) i_chk (.ref_clk(ref_clk), .rstn(rstn),
    .cs_n(cs_n), .serial_clock(serial_clock), .din(din), .dout_q(dout_q),
    .dout_oe_q(dout_oe_q), .sig_in(sig_in), .irq_q(irq_q));
`default_nettype wire

// File: scp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host controller side: bit-banged half-duplex port, data pins strapped
module scp_host_model (
    output logic     cs_n,
    output logic     serial_clock,
    output logic     din,
    input wire logic dout_q,
    input wire logic dout_oe_q
);
    logic host_oe = 1'b0;  // host drives the shared line
    logic host_bit = 1'b0; // last bit the host put out
    initial cs_n = 1'b1;
    initial serial_clock = 1'b1;
    // shared line; nobody driving shows the inverse of the last host bit
    assign din = dout_oe_q ? dout_q : (host_oe ? host_bit : ~host_bit);
    task start();
        cs_n = 1'b0;
        #400;
    endtask
    // top n bits of one byte, msb first; drives the line only when drv is set, samples it on every rise
    task xbyte(input logic [7:0] tx, input logic drv, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            serial_clock = 1'b0;
            host_oe = drv;
            if (drv) host_bit = tx[i];
            #200;
            serial_clock = 1'b1;
            rx[i] = din;
            #200;
        end
    endtask
    // clock stays high between bytes and while deselected
    task stop();
        #200;
        host_oe = 1'b0;
        cs_n = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

// File: scp_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scp_regs.vh"
module scp_tb_top;
    logic       ref_clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] sig_in = 8'h00;
    wire logic  cs_n, serial_clock, din, dout_q, dout_oe_q, irq_q;
    int         fail_count = 0;
    int         check_count = 0;
    logic [7:0] rx [0:8];   // bytes returned by the last read
    logic [7:0] dummy;
    always #25 ref_clk = ~ref_clk;
    // short debounce keeps the interrupt scenario brief
    scp_top #(.SIG_W(8), .DEB(16'h0004)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n),
        .serial_clock(serial_clock), .din(din), .dout_q(dout_q), .dout_oe_q(dout_oe_q),
        .sig_in(sig_in), .irq_q(irq_q));
    scp_host_model i_host (.cs_n(cs_n), .serial_clock(serial_clock), .din(din),
        .dout_q(dout_q), .dout_oe_q(dout_oe_q));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // write n bytes d0, 2*d0, ...
    task wr(input logic [7:0] cmd, input logic [7:0] d0, input int n);
        i_host.start();
        i_host.xbyte(cmd, 1'b1, 8, dummy);
        for (int j = 0; j < n; j++) i_host.xbyte(8'(d0 * (j + 1)), 1'b1, 8, dummy);
        i_host.stop();
    endtask
    // read id plus n bytes, clock held high after byte number pause
    task rd(input logic [7:0] cmd, input int n, input int pause);
        i_host.start();
        i_host.xbyte(cmd, 1'b1, 8, dummy);
        for (int k = 0; k <= n; k++) begin
            i_host.xbyte(8'h00, 1'b0, 8, rx[k]);
            if (k == pause) #3000;
        end
        i_host.stop();
    endtask
    // full eight-byte write and read-back with a pause mid-read
    task t_bulk();
        wr(8'h17, 8'h11, 8);
        rd(8'h37, 8, 1);
        check(rx[0], `SCP_ID_BYTE);
        for (int j = 0; j < 8; j++) check(rx[j + 1], 8'(8'h11 * (j + 1)));
        check({7'h0, dout_oe_q}, 8'h00);
    endtask
    // aborted byte, then class separation between status and coefficients
    task t_abort();
        i_host.start();
        i_host.xbyte(8'h10, 1'b1, 8, dummy);
        i_host.xbyte(8'hff, 1'b1, 4, dummy);
        i_host.stop();
        wr(8'h00, 8'h3c, 1);
        rd(8'h30, 1, 9);
        check(rx[1], 8'h88);
        rd(8'h20, 1, 9);
        check(rx[1], 8'h3c);
        // one fall past the last byte hands the line back while still selected
        i_host.start();
        i_host.xbyte(8'h20, 1'b1, 8, dummy);
        for (int k = 0; k < 2; k++) i_host.xbyte(8'h00, 1'b0, 8, rx[k]);
        i_host.xbyte(8'h00, 1'b0, 1, dummy);
        check({7'h0, dout_oe_q}, 8'h00);
        i_host.stop();
        check(rx[1], 8'h3c);
    endtask
    // input change raises the interrupt; extended read returns and clears it
    task t_irq();
        int w;
        @(negedge ref_clk);
        sig_in = 8'ha5;
        for (w = 0; w < 200 && irq_q !== 1'b1; w++) @(negedge ref_clk);
        check({7'h0, irq_q}, 8'h01);
        if (w == 200) wrap_up();
        rd(8'h38, 1, 9);
        check(rx[1], 8'ha5);
        check({7'h0, irq_q}, 8'h00);
    endtask
    initial begin
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (6) @(negedge ref_clk);
        check({6'h0, dout_oe_q, irq_q}, 8'h00);
        t_bulk();
        t_abort();
        t_irq();
        wrap_up();
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        fail_count++;
        $display("unexpected at %0t: run timed out", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
